// ===== verilog/mcic_regs.svh
// constants for the fan-controller serial configuration port
`ifndef MCIC_REGS_SVH
`define MCIC_REGS_SVH
// ==================================================
// target side map
`define MC_TARGET_ADDR 7'h55
`define MC_NV_REG_OFS 8'h40
`define MC_NV_FIRST 8'h08
`define MC_NV_LAST 8'h16
`define MC_SPEED_RATING_CONFIG 8'h48
`define MC_ACCEL_RESISTANCE_CONFIG 8'h49
`define MC_CURRENT_RATING_CONFIG 8'h4a
`define MC_STARTUP_DRIVE_CONFIG 8'h4b
`define MC_OBSERVER_GAIN_CONFIG 8'h4c
`define MC_OBSERVER_INTEGRAL_CONFIG 8'h4d
`define MC_PIN_OPTION_CONFIG 8'h4e
`define MC_PROTECTION_TIMING_CONFIG 8'h4f
`define MC_OVERCURRENT_CONFIG 8'h50
`define MC_HOST_SPEED_COMMAND 8'h51
`define MC_GATE_DRIVE_CONFIG 8'h52
`define MC_GATE_CAPACITANCE_CONFIG 8'h53
`define MC_VOLTAGE_SHUNT_CONFIG 8'h54
`define MC_STANDBY_THRESHOLD_CONFIG 8'h55
`define MC_RESTART_BRAKE_CONFIG 8'h56
`define MC_PULSE_REDIRECT_REG 8'ha5
`define MC_PULSE_REDIRECT_VAL 16'h00a0
`define MC_OCP_OFF 3'h7
`define MC_PULSE_DIS_BIT 4
`define MC_DIRECT_ANGLE_BIT 5
`define MC_HOST_SPEED_BIT 9
`define MC_LOCK_LONG_BIT 11
// ==================================================
// timing
`define MC_CLK_NS 100
`define MC_HOLD_US 9800
`define MC_LOCK_SHORT_MS 5000
`define MC_LOCK_LONG_MS 10000
`define MC_DT_STEP_NS 40
`define MC_ILIM_NUM 13
`define MC_ILIM_DEN 10
// ==================================================
// controller side map
`define MC_H_CTRL 8'h00
`define MC_H_WDATA 8'h04
`define MC_H_RDATA 8'h08
`define MC_H_STAT 8'h0c
`define MC_H_CTRL_RD 8
`define MC_H_CTRL_GO 9
`endif

// ===== verilog/mcic_pkg.sv
// types shared by both ends of the configuration link
package mcic_pkg;
	// ==================================================
	// target serial receive and transmit states
	typedef enum logic [2:0] {D_IDLE, D_ADDR, D_RX, D_ACK, D_TX, D_TXACK} mcic_dst_e;
	// controller sequence steps
	typedef enum logic [2:0] {O_START, O_WR, O_RD, O_STOP, O_DONE} mcic_op_e;
	typedef logic [26:0] mcic_tmr_t; // long timers
	// target state
	typedef struct packed {
		mcic_dst_e st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic rw;
		logic [1:0] bi;
		logic [7:0] ptr;
		logic [7:0] hi;
		logic [15:0] tx;
		logic nack;
		logic i2c_oe;
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic [1:0] ov_s;
		logic [1:0][2:0] uv_s;
		logic [1:0][5:0] vds_s;
		logic [14:0][15:0] cfg;
		logic redir;
		logic cmd_seen;
		mcic_tmr_t hold;
		mcic_tmr_t lock_t;
		logic [2:0][2:0] dt;
		logic sda_oe;
		logic drive;
		logic ov;
		logic overcurrent_stop;
		logic ilim;
		logic sys_err;
		logic [4:0] angle;
		logic [8:0] spd;
		logic [2:0] ghi;
		logic [2:0] glo;
		logic fault_oe;
	} mcic_dev_s;
	// controller state
	typedef struct packed {
		logic busy;
		logic [3:0] step;
		logic [3:0] bitn;
		logic [1:0] qp;
		logic [2:0] tk;
		logic [7:0] sh;
		logic [15:0] rx;
		logic scl_oe;
		logic sda_oe;
		logic [1:0] sda_s;
		logic [7:0] ra;
		logic rd;
		logic [15:0] wd;
		logic [15:0] rdat;
		logic nack;
		logic done;
		logic refused;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} mcic_host_s;
endpackage

// ===== verilog/mcic_link_if.sv
// open-drain serial link between controller and target
`timescale 1ns/1ps
interface mcic_link_if;
	logic host_scl_o; // clock level when driven
	logic host_scl_oe; // controller pulls clock
	logic host_sda_o; // data level when driven
	logic host_sda_oe; // controller pulls data
	logic dev_sda_o; // target data level when driven
	logic dev_sda_oe; // target pulls data
	logic scl; // resolved clock wire
	logic sda; // resolved data wire
	// pull-ups win unless someone drives low
	assign scl = host_scl_oe ? host_scl_o : 1'b1;
	assign sda = (host_sda_oe ? host_sda_o : 1'b1) & (dev_sda_oe ? dev_sda_o : 1'b1);
	modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
	modport host (input scl, input sda, output host_scl_o, output host_scl_oe,
		output host_sda_o, output host_sda_oe);
endinterface // mcic_link_if

// ===== verilog/mcic_dev.sv
// target end: serial port, configuration bank and protection supervision
`timescale 1ns/1ps
`include "mcic_regs.svh"
module mcic_dev #(
	parameter logic [14:0][15:0] NV_IMAGE = '0, // stored defaults, words 8..22
	parameter mcic_pkg::mcic_tmr_t HOLD_CYC =
		27'((`MC_HOLD_US * 1000 + `MC_CLK_NS - 1) / `MC_CLK_NS),
	parameter mcic_pkg::mcic_tmr_t LOCK_SHORT_CYC =
		27'(`MC_LOCK_SHORT_MS * (1000000 / `MC_CLK_NS)),
	parameter mcic_pkg::mcic_tmr_t LOCK_LONG_CYC =
		27'(`MC_LOCK_LONG_MS * (1000000 / `MC_CLK_NS))
) (
	input wire logic CLOCK,
	input wire logic RST,
	mcic_link_if.device LNK,
	input wire logic SPEED_PULSE,
	input wire logic STANDBY_EXIT,
	input wire logic [2:0] UV_RAW,
	input wire logic OV_RAW,
	input wire logic LOCK_DET,
	input wire logic [5:0] VDS_HIGH,
	input wire logic [5:0] SW_EN,
	input wire logic RESTART,
	input wire logic [10:0] PHASE_PEAK,
	input wire logic ACCEL,
	input wire logic [4:0] CALC_ANGLE,
	input wire logic [8:0] PIN_DEMAND,
	input wire logic [2:0] HI_REQ,
	input wire logic [2:0] LO_REQ,
	output logic DRIVE_EN,
	output logic SYSTEM_ERROR,
	output logic OVERVOLTAGE_FLAG,
	output logic OVERCURRENT_STOP,
	output logic CURRENT_LIMIT,
	output logic [4:0] PHASE_ANGLE,
	output logic [8:0] SPEED_DEMAND,
	output logic [2:0] GATE_HI,
	output logic [2:0] GATE_LO,
	output logic FAULT_OE
);
	import mcic_pkg::*;

	// ==================================================
	// helpers
	// true when the pointer hits a mirrored word
	function automatic logic in_map(input logic [7:0] p);
		in_map = p >= (`MC_NV_FIRST + `MC_NV_REG_OFS) && p <= (`MC_NV_LAST + `MC_NV_REG_OFS);
	endfunction

	// dead-time cycles, rounded up so the gap is never short
	function automatic logic [2:0] dt_cycles(input logic [3:0] n);
		dt_cycles = 3'(((32'(n) + 1) * `MC_DT_STEP_NS + `MC_CLK_NS - 1) / `MC_CLK_NS);
	endfunction

	mcic_dev_s q; // all state
	mcic_dev_s n; // next state
	logic [3:0] cidx; // bank index for reads and writes
	logic scl_r; // clock rising
	logic scl_f; // clock falling
	logic sd; // synchronised data
	logic start; // start condition
	logic stop; // stop condition
	logic ocp_en; // short detection armed
	logic sysu; // any undervoltage
	logic drv; // drive permitted this cycle
	logic [15:0] wword; // assembled write word
	logic [15:0] rword; // word returned on read
	logic [2:0] dtc; // dead-time load value

	// ==================================================
	// next-state logic
	always_comb begin
		n = q;
		cidx = 4'(q.ptr - (`MC_NV_FIRST + `MC_NV_REG_OFS));
		// pins from the link pass two flops before use
		n.scl_s = {q.scl_s[1:0], LNK.scl};
		n.sda_s = {q.sda_s[1:0], LNK.sda};
		n.uv_s = {q.uv_s[0], UV_RAW};
		n.ov_s = {q.ov_s[0], OV_RAW};
		n.vds_s = {q.vds_s[0], VDS_HIGH};
		scl_r = q.scl_s[1] & ~q.scl_s[2];
		scl_f = ~q.scl_s[1] & q.scl_s[2];
		sd = q.sda_s[1];
		start = q.scl_s[1] & q.scl_s[2] & q.sda_s[2] & ~sd;
		stop = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[2] & sd;
		wword = {q.hi, q.sh};
		// unmapped reads answer zero
		if (in_map(q.ptr)) begin
			rword = q.cfg[cidx];
		end else if (q.ptr == `MC_PULSE_REDIRECT_REG) begin
			rword = q.redir ? `MC_PULSE_REDIRECT_VAL : 16'h0000;
		end else begin
			rword = 16'h0000;
		end
		// serial target
		if (start) begin
			n.st = D_ADDR;
			n.cnt = 4'h0;
			n.i2c_oe = 1'b0;
		end else if (stop) begin
			n.st = D_IDLE;
			n.i2c_oe = 1'b0;
		end else begin
			unique case (q.st)
				D_IDLE: begin
				end
				D_ADDR, D_RX: begin
					if (scl_r) begin
						n.sh = {q.sh[6:0], sd};
						n.cnt = q.cnt + 4'h1;
					end else if (scl_f && q.cnt == 4'h8) begin
						n.cnt = 4'h0;
						if (q.st == D_ADDR) begin
							if (q.sh[7:1] == `MC_TARGET_ADDR) begin
								n.st = D_ACK;
								n.i2c_oe = 1'b1;
								n.rw = q.sh[0];
								n.bi = 2'h0;
								n.cmd_seen = 1'b1;
								n.tx = rword;
							end else begin
								n.st = D_IDLE;
							end
						end else if (q.bi == 2'h3) begin
							n.st = D_IDLE; // bytes past the word are not acknowledged
						end else begin
							n.st = D_ACK;
							n.i2c_oe = 1'b1;
							n.bi = q.bi + 2'h1;
							if (q.bi == 2'h0) begin
								n.ptr = q.sh;
							end else if (q.bi == 2'h1) begin
								n.hi = q.sh; // high byte first
							end else if (in_map(q.ptr)) begin
								n.cfg[cidx] = wword;
							end else if (q.ptr == `MC_PULSE_REDIRECT_REG) begin
								n.redir = wword == `MC_PULSE_REDIRECT_VAL;
							end
						end
					end
				end
				D_ACK: begin
					if (scl_f) begin
						n.i2c_oe = q.rw & ~q.tx[15];
						n.st = q.rw ? D_TX : D_RX;
					end
				end
				D_TX: begin
					if (scl_r) begin
						n.cnt = q.cnt + 4'h1;
					end else if (scl_f) begin
						n.tx = {q.tx[14:0], 1'b0};
						if (q.cnt == 4'h8) begin
							n.i2c_oe = 1'b0;
							n.st = D_TXACK;
						end else begin
							n.i2c_oe = ~q.tx[14];
						end
					end
				end
				D_TXACK: begin
					if (scl_r) begin
						n.nack = sd;
					end else if (scl_f) begin
						n.cnt = 4'h0;
						if (q.nack) begin
							n.st = D_IDLE;
						end else begin
							n.st = D_TX;
							n.i2c_oe = ~q.tx[15];
						end
					end
				end
			endcase
		end
		// startup hold re-armed by standby exit
		if (STANDBY_EXIT) begin
			n.hold = HOLD_CYC;
			n.cmd_seen = 1'b0;
		end else if (q.hold != '0) begin
			n.hold = q.hold - 27'h1;
		end
		// shared data pin: serial drive, or speed pulses before any command
		n.sda_oe = n.i2c_oe | (q.hold == '0 & ~n.cmd_seen
			& ~q.cfg[6][`MC_PULSE_DIS_BIT] & ~SPEED_PULSE);
		// supervision
		sysu = |q.uv_s[1];
		n.sys_err = sysu;
		n.ov = q.ov_s[1];
		ocp_en = q.cfg[8][2:0] != `MC_OCP_OFF;
		if (RESTART) begin
			n.overcurrent_stop = 1'b0;
		end
		if (ocp_en && |(q.vds_s[1] & SW_EN)) begin
			n.overcurrent_stop = 1'b1;
		end
		if (q.lock_t != '0) begin
			n.lock_t = q.lock_t - 27'h1;
		end else if (LOCK_DET) begin
			n.lock_t = q.cfg[14][`MC_LOCK_LONG_BIT] ? LOCK_LONG_CYC : LOCK_SHORT_CYC;
		end
		drv = ~sysu & ~n.overcurrent_stop & (n.lock_t == '0);
		n.drive = drv;
		n.ilim = ACCEL & (16'(PHASE_PEAK) * 16'(`MC_ILIM_DEN) >
			16'(q.cfg[2][10:0]) * 16'(`MC_ILIM_NUM));
		n.angle = q.cfg[3][`MC_DIRECT_ANGLE_BIT] ? q.cfg[4][12:8] : CALC_ANGLE;
		n.spd = q.cfg[9][`MC_HOST_SPEED_BIT] ? q.cfg[9][8:0] : PIN_DEMAND;
		// fault pin shows faults, or the speed pulse once redirected
		n.fault_oe = q.redir ? ~SPEED_PULSE : (sysu | q.overcurrent_stop | q.lock_t != '0);
		// half-bridges: both off, wait dead time, then the new side
		dtc = dt_cycles(q.cfg[7][11:8]);
		for (int p = 0; p < 3; p++) begin
			if ((q.ghi[p] & ~HI_REQ[p]) | (q.glo[p] & ~LO_REQ[p]) | ~drv) begin
				n.ghi[p] = 1'b0;
				n.glo[p] = 1'b0;
				if (q.ghi[p] | q.glo[p]) begin
					n.dt[p] = dtc;
				end
			end else if (q.dt[p] != 3'h0) begin
				n.dt[p] = q.dt[p] - 3'h1;
			end else begin
				n.ghi[p] = HI_REQ[p] & ~LO_REQ[p];
				n.glo[p] = LO_REQ[p] & ~HI_REQ[p];
			end
		end
	end

	// ==================================================
	// state register; reset loads the stored defaults
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			q <= '0;
			q.cfg <= NV_IMAGE;
			q.hold <= HOLD_CYC;
			q.scl_s <= '1;
			q.sda_s <= '1;
		end else begin
			q <= n;
		end
	end

	// ==================================================
	// outputs, all from flops
	assign LNK.dev_sda_o = 1'b0;
	assign LNK.dev_sda_oe = q.sda_oe;
	assign DRIVE_EN = q.drive;
	assign SYSTEM_ERROR = q.sys_err;
	assign OVERVOLTAGE_FLAG = q.ov;
	assign OVERCURRENT_STOP = q.overcurrent_stop;
	assign CURRENT_LIMIT = q.ilim;
	assign PHASE_ANGLE = q.angle;
	assign SPEED_DEMAND = q.spd;
	assign GATE_HI = q.ghi;
	assign GATE_LO = q.glo;
	assign FAULT_OE = q.fault_oe;
endmodule // mcic_dev

// ===== verilog/mcic_host.sv
// controller end: APB command registers driving the serial link
`timescale 1ns/1ps
`include "mcic_regs.svh"
module mcic_host #(
	parameter logic [2:0] QTR = 3'h4 // cycles per quarter bit
) (
	input wire logic CLOCK,
	input wire logic RST,
	mcic_link_if.host LNK,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR
);
	import mcic_pkg::*;

	// ==================================================
	// transfer sequences
	// write: start, addr+w, pointer, hi, lo, stop; read adds stop/start
	function automatic mcic_op_e seq_op(input logic [3:0] s, input logic rd);
		if (!rd) begin
			seq_op = s == 4'h0 ? O_START : s <= 4'h4 ? O_WR : s == 4'h5 ? O_STOP : O_DONE;
		end else begin
			unique case (s)
				4'h0, 4'h4: seq_op = O_START;
				4'h1, 4'h2, 4'h5: seq_op = O_WR;
				4'h3, 4'h8: seq_op = O_STOP;
				4'h6, 4'h7: seq_op = O_RD;
				default: seq_op = O_DONE;
			endcase
		end
	endfunction

	// byte sent at a write step
	function automatic logic [7:0] seq_byte(input logic [3:0] s, input mcic_host_s h);
		unique case (s)
			4'h1: seq_byte = {`MC_TARGET_ADDR, 1'b0};
			4'h2: seq_byte = h.ra;
			4'h3: seq_byte = h.wd[15:8];
			4'h5: seq_byte = {`MC_TARGET_ADDR, 1'b1};
			default: seq_byte = h.wd[7:0];
		endcase
	endfunction

	mcic_host_s q; // all state
	mcic_host_s n; // next state
	mcic_op_e op; // current step kind
	logic endq; // last cycle of a quarter
	logic acc; // APB access taken
	logic sd; // synchronised data
	logic mapped; // write target exists

	// ==================================================
	// next-state logic
	always_comb begin
		n = q;
		n.sda_s = {q.sda_s[0], LNK.sda};
		sd = q.sda_s[1];
		op = seq_op(q.step, q.rd);
		endq = q.tk == QTR - 3'h1;
		acc = PSEL & PENABLE & ~q.pready;
		mapped = (PWDATA[7:0] >= `MC_SPEED_RATING_CONFIG && PWDATA[7:0] <= `MC_RESTART_BRAKE_CONFIG)
			|| PWDATA[7:0] == `MC_PULSE_REDIRECT_REG;
		// serial engine; no wait after reset so the first transfer is early
		if (q.busy) begin
			n.tk = endq ? 3'h0 : q.tk + 3'h1;
			if (endq) begin
				n.qp = q.qp + 2'h1;
				unique case (op)
					O_START: begin
						if (q.qp == 2'h0) begin
							n.sda_oe = 1'b1;
						end else if (q.qp == 2'h3) begin
							n.scl_oe = 1'b1;
							n.step = q.step + 4'h1;
							n.sh = seq_byte(q.step + 4'h1, q);
							n.bitn = 4'h0;
						end
					end
					O_WR, O_RD: begin
						if (q.qp == 2'h0) begin
							if (q.bitn == 4'h8) begin
								n.sda_oe = op == O_RD && q.step == 4'h6; // ack first, not last
							end else begin
								n.sda_oe = op == O_WR && !q.sh[7];
							end
						end else if (q.qp == 2'h1) begin
							n.scl_oe = 1'b0;
						end else if (q.qp == 2'h3) begin
							n.scl_oe = 1'b1;
							n.bitn = q.bitn + 4'h1;
							if (q.bitn != 4'h8) begin
								n.sh = {q.sh[6:0], 1'b0};
								if (op == O_RD) begin
									n.rx = {q.rx[14:0], sd};
								end
							end else begin
								n.bitn = 4'h0;
								n.step = q.step + 4'h1;
								n.sh = seq_byte(q.step + 4'h1, q);
								if (op == O_WR && sd) begin
									n.nack = 1'b1;
									n.step = q.rd ? 4'h8 : 4'h5;
								end
							end
						end
					end
					O_STOP: begin
						if (q.qp == 2'h0) begin
							n.sda_oe = 1'b1;
						end else if (q.qp == 2'h1) begin
							n.scl_oe = 1'b0;
						end else if (q.qp == 2'h2) begin
							n.sda_oe = 1'b0;
						end else begin
							n.step = q.step + 4'h1;
						end
					end
					O_DONE: begin
						n.busy = 1'b0;
						n.done = 1'b1;
						n.rdat = q.rx;
					end
				endcase
			end
		end
		// APB slave: one wait state, answer registered
		n.pready = acc;
		n.prdata = 32'h0;
		n.pslverr = 1'b0;
		if (acc) begin
			unique case (PADDR)
				`MC_H_CTRL: begin
					n.prdata = {23'h0, q.rd, q.ra};
					if (PWRITE) begin
						n.ra = PWDATA[7:0];
						n.rd = PWDATA[`MC_H_CTRL_RD];
						if (PWDATA[`MC_H_CTRL_GO] && !q.busy) begin
							// unmapped write targets are refused
							n.refused = !PWDATA[`MC_H_CTRL_RD] && !mapped;
							n.busy = PWDATA[`MC_H_CTRL_RD] || mapped;
							n.done = 1'b0;
							n.nack = 1'b0;
							n.step = 4'h0;
							n.qp = 2'h0;
							n.tk = 3'h0;
						end
					end
				end
				`MC_H_WDATA: begin
					n.prdata = {16'h0, q.wd};
					if (PWRITE) begin
						n.wd = PWDATA[15:0];
					end
				end
				`MC_H_RDATA: n.prdata = {16'h0, q.rdat};
				`MC_H_STAT: n.prdata = {28'h0, q.refused, q.done, q.nack, q.busy};
				default: n.pslverr = 1'b1;
			endcase
		end
	end

	// ==================================================
	// state register
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			q <= '0;
			q.sda_s <= '1;
		end else begin
			q <= n;
		end
	end

	// ==================================================
	// outputs, all from flops
	assign LNK.host_scl_o = 1'b0;
	assign LNK.host_scl_oe = q.scl_oe;
	assign LNK.host_sda_o = 1'b0;
	assign LNK.host_sda_oe = q.sda_oe;
	assign PRDATA = q.prdata;
	assign PREADY = q.pready;
	assign PSLVERR = q.pslverr;
endmodule // mcic_host

// ===== testbench/mcic_link_sva.sv
// wire-level checks of the open-drain configuration link
`timescale 1ns/1ps
module mcic_link_sva #(
	parameter int HOLD_CYC = 50 // release time after reset, cycles
) (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic host_scl_o,
	input wire logic host_scl_oe,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic scl,
	input wire logic sda
);
	// ==================================================
	// frame tracking
	logic frm_q; // inside a start..stop frame
	logic adr_q; // still in the address byte
	logic [3:0] bit_q; // bit count within a byte
	logic [7:0] sh_q; // bits seen at clock rises
	logic [31:0] age_q; // cycles since reset release
	logic scl_q;
	logic hoe_q;
	// only the controller's own data enable marks frames, so speed pulses
	// from the target can never be mistaken for a start
	always_ff @(posedge CLOCK) begin
		scl_q <= scl;
		hoe_q <= host_sda_oe;
		if (RST) begin
			frm_q <= 1'b0;
			adr_q <= 1'b0;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			age_q <= 32'h0;
		end else begin
			if (age_q < 32'(HOLD_CYC)) begin
				age_q <= age_q + 32'h1;
			end
			if (scl && !hoe_q && host_sda_oe) begin // start
				frm_q <= 1'b1;
				adr_q <= 1'b1;
				bit_q <= 4'h0;
			end else if (scl && hoe_q && !host_sda_oe) begin // stop
				frm_q <= 1'b0;
			end else if (frm_q && scl && !scl_q) begin // clock rise
				sh_q <= {sh_q[6:0], sda};
				bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
				adr_q <= adr_q && (bit_q != 4'h8);
			end
		end
	end
	// ==================================================
	// assertions
	a_hold_release: assert property (@(posedge CLOCK) disable iff (RST)
		age_q < 32'(HOLD_CYC - 1) && !frm_q |-> !dev_sda_oe)
		else $error("data pin pulled during hold");
	a_addr_ack: assert property (@(posedge CLOCK) disable iff (RST)
		frm_q && adr_q && bit_q == 4'h8 && scl && !scl_q |-> sda == (sh_q[7:1] != 7'h55))
		else $error("address ack wrong");
	a_dev_change_low: assert property (@(posedge CLOCK) disable iff (RST)
		frm_q && $changed(dev_sda_oe) |-> !scl)
		else $error("target data changed while clock high");
	a_clock_high_time: assert property (@(posedge CLOCK) disable iff (RST)
		$rose(scl) |-> scl[*8])
		else $error("clock high phase short");
	a_clock_low_time: assert property (@(posedge CLOCK) disable iff (RST)
		$fell(scl) |-> (!scl)[*8])
		else $error("clock low phase short");
	a_no_mid_start: assert property (@(posedge CLOCK) disable iff (RST)
		frm_q && scl && scl_q |-> !$fell(sda))
		else $error("data fell while clock high in frame");
	a_scl_open_drain: assert property (@(posedge CLOCK) disable iff (RST)
		host_scl_oe |-> !host_scl_o)
		else $error("clock driven high");
	a_sda_open_drain: assert property (@(posedge CLOCK) disable iff (RST)
		dev_sda_oe |-> !dev_sda_o)
		else $error("data driven high");
endmodule // mcic_link_sva

// ===== testbench/test_motor_ctrl_i2c_config_regs.sv
// self-checking bench joining both ends of the configuration link
`timescale 1ns/1ps
`include "mcic_regs.svh"
module test_motor_ctrl_i2c_config_regs;
	import mcic_pkg::*;
	// ==================================================
	// stimulus and observed signals
	logic clock = 1'b0;
	logic rst = 1'b1; // held for 8 cycles
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr;
	logic spd = 1'b0, stby = 1'b0, ov = 1'b0, lock = 1'b0, rs = 1'b0, accel = 1'b0;
	logic [2:0] uv = 3'h0;
	logic [5:0] vds = 6'h00, sw_en = 6'h00;
	logic [10:0] peak = 11'h000;
	logic [4:0] calc = 5'h03, angle;
	logic [8:0] pin_dem = 9'h0a5, demand;
	logic drv, serr, ovf, ocs, clim, fault_oe;
	logic [2:0] hi_req = 3'h0, lo_req = 3'h0, gh, gl; // gate requests and gates
	int mismatches = 0;
	int check_count = 0;
	// stored words: word i reads back as i in the high byte
	function automatic logic [14:0][15:0] nv_img();
		logic [14:0][15:0] v;
		for (int i = 0; i < 15; i++) v[i] = {4'h0, 4'(i), 8'h00};
		return v;
	endfunction
	localparam logic [14:0][15:0] IMG = nv_img();
	always #50 clock = ~clock;
	// ==================================================
	// both ends and the checker
	mcic_link_if i_mcic_link_if();
	mcic_dev #(.NV_IMAGE(IMG), .HOLD_CYC(27'd50), .LOCK_SHORT_CYC(27'd40),
		.LOCK_LONG_CYC(27'd80)) i_mcic_dev (.CLOCK(clock), .RST(rst),
		.LNK(i_mcic_link_if.device), .SPEED_PULSE(spd), .STANDBY_EXIT(stby), .UV_RAW(uv),
		.OV_RAW(ov), .LOCK_DET(lock), .VDS_HIGH(vds), .SW_EN(sw_en), .RESTART(rs),
		.PHASE_PEAK(peak), .ACCEL(accel), .CALC_ANGLE(calc), .PIN_DEMAND(pin_dem),
		.HI_REQ(hi_req), .LO_REQ(lo_req), .DRIVE_EN(drv), .SYSTEM_ERROR(serr),
		.OVERVOLTAGE_FLAG(ovf), .OVERCURRENT_STOP(ocs), .CURRENT_LIMIT(clim),
		.PHASE_ANGLE(angle), .SPEED_DEMAND(demand), .GATE_HI(gh), .GATE_LO(gl),
		.FAULT_OE(fault_oe));
	mcic_host #(.QTR(3'h4)) i_mcic_host (.CLOCK(clock), .RST(rst),
		.LNK(i_mcic_link_if.host), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	mcic_link_sva #(.HOLD_CYC(50)) i_mcic_link_sva (.CLOCK(clock), .RST(rst),
		.host_scl_o(i_mcic_link_if.host_scl_o), .host_scl_oe(i_mcic_link_if.host_scl_oe),
		.host_sda_o(i_mcic_link_if.host_sda_o), .host_sda_oe(i_mcic_link_if.host_sda_oe),
		.dev_sda_o(i_mcic_link_if.dev_sda_o), .dev_sda_oe(i_mcic_link_if.dev_sda_oe),
		.scl(i_mcic_link_if.scl), .sda(i_mcic_link_if.sda));
	// ==================================================
	// common tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	// one bus transfer; an idle cycle follows so requests never collide
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			mismatches++;
			print_verdict();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	// one serial operation, polled until the controller is idle
	task automatic xfer(input logic rd, input logic [7:0] r, input logic [15:0] d,
			output logic [15:0] q, output logic [3:0] st);
		logic [31:0] x;
		logic e;
		int n;
		if (!rd) apb(1'b1, `MC_H_WDATA, {16'h0, d}, x, e);
		apb(1'b1, `MC_H_CTRL, {22'h0, 1'b1, rd, r}, x, e);
		n = 0;
		do begin
			apb(1'b0, `MC_H_STAT, 32'h0, x, e);
			n++;
		end while (x[0] !== 1'b0 && n < 800);
		if (x[0] !== 1'b0) begin
			mismatches++;
			print_verdict();
		end
		st = x[3:0];
		apb(1'b0, `MC_H_RDATA, 32'h0, x, e);
		q = x[15:0];
	endtask
	task automatic wr(input logic [7:0] r, input logic [15:0] d);
		logic [15:0] q;
		logic [3:0] st;
		xfer(1'b0, r, d, q, st);
		chk(st, 4'h4);
	endtask
	task automatic rdc(input logic [7:0] r, input logic [15:0] v);
		logic [15:0] q;
		logic [3:0] st;
		xfer(1'b1, r, 16'h0, q, st);
		chk({st, q}, {4'h4, v});
	endtask
	// ==================================================
	// scenarios
	// hold after reset, first command inside it, pulses gone afterwards
	task automatic t_startup();
		cyc(30);
		chk(i_mcic_link_if.sda, 1'b1);
		spd <= 1'b1;
		wr(`MC_SPEED_RATING_CONFIG, 16'hc35a);
		spd <= 1'b0;
		cyc(20);
		chk(i_mcic_link_if.sda, 1'b1);
		rdc(`MC_SPEED_RATING_CONFIG, 16'hc35a);
		rdc(`MC_ACCEL_RESISTANCE_CONFIG, IMG[1]);
		rdc(`MC_RESTART_BRAKE_CONFIG, IMG[14]);
	endtask
	// standby exit rearms hold and pulses unless pulses are disabled
	task automatic t_standby(input logic dis);
		stby <= 1'b1;
		cyc(1);
		stby <= 1'b0;
		cyc(30);
		chk(i_mcic_link_if.sda, 1'b1);
		cyc(40);
		chk(i_mcic_link_if.sda, dis);
		spd <= 1'b1;
		cyc(4);
	endtask
	task automatic t_redirect();
		wr(`MC_PULSE_REDIRECT_REG, `MC_PULSE_REDIRECT_VAL);
		spd <= 1'b0;
		cyc(4);
		chk(fault_oe, 1'b1);
		spd <= 1'b1;
		cyc(4);
		chk(fault_oe, 1'b0);
		rdc(`MC_PULSE_REDIRECT_REG, `MC_PULSE_REDIRECT_VAL);
	endtask
	// unmapped target register write and unmapped bus address are refused, unmapped register read answers zero
	task automatic t_refuse();
		logic [31:0] x;
		logic e;
		logic [15:0] q;
		logic [3:0] st;
		xfer(1'b0, 8'h60, 16'h1234, q, st);
		chk(st, 4'h8);
		apb(1'b0, 8'h10, 32'h0, x, e);
		chk(e, 1'b1);
		rdc(8'h47, 16'h0000);
	endtask
	// half-bridge swap keeps both switches off for the dead time
	task automatic t_deadtime();
		int n;
		int gap;
		hi_req <= 3'h1;
		cyc(3);
		chk({gh, gl}, 6'b001000);
		hi_req <= 3'h0;
		lo_req <= 3'h1;
		n = 0;
		gap = 0;
		do begin
			@(posedge clock);
			n++;
			if ({gh, gl} === 6'h00) gap++;
		end while (gl !== 3'h1 && n < 32);
		if (gl !== 3'h1) begin
			mismatches++;
			print_verdict();
		end
		// stored timing word selects step 7: eight 40 ns steps rounded up to
		// whole cycles, plus the register stage that applies the new side
		chk(gap, 32'((8 * `MC_DT_STEP_NS + `MC_CLK_NS - 1) / `MC_CLK_NS + 1));
		lo_req <= 3'h0;
		cyc(2);
		chk({gh, gl}, 6'h00);
	endtask
	task automatic t_modes();
		chk(demand, pin_dem);
		wr(`MC_HOST_SPEED_COMMAND, 16'h0323);
		cyc(4);
		chk(demand, 9'h123);
		chk(angle, calc);
		wr(`MC_OBSERVER_GAIN_CONFIG, 16'h1700);
		wr(`MC_STARTUP_DRIVE_CONFIG, 16'h0020);
		cyc(4);
		chk(angle, 5'h17);
		wr(`MC_CURRENT_RATING_CONFIG, 16'h0064);
		accel <= 1'b1;
		peak <= 11'd131;
		cyc(4);
		chk(clim, 1'b1);
		peak <= 11'd130;
		cyc(4);
		chk(clim, 1'b0);
	endtask
	task automatic t_faults();
		sw_en <= 6'h02;
		vds <= 6'h01;
		cyc(6);
		chk(ocs, 1'b0);
		sw_en <= 6'h01;
		cyc(6);
		chk({ocs, drv}, 2'b10);
		vds <= 6'h00;
		// let the synchroniser empty first: a set wins over the restart
		cyc(4);
		rs <= 1'b1;
		cyc(1);
		rs <= 1'b0;
		cyc(4);
		chk({ocs, drv}, 2'b01);
		uv <= 3'h2;
		cyc(6);
		chk({serr, drv}, 2'b10);
		uv <= 3'h0;
		ov <= 1'b1;
		cyc(6);
		chk({serr, ovf, drv}, 3'b011);
		ov <= 1'b0;
		lock <= 1'b1;
		cyc(1);
		lock <= 1'b0;
		cyc(60);
		chk({ovf, drv}, 2'b00);
		cyc(40);
		chk(drv, 1'b1);
		wr(`MC_RESTART_BRAKE_CONFIG, 16'h0000);
		lock <= 1'b1;
		cyc(1);
		lock <= 1'b0;
		cyc(30);
		chk(drv, 1'b0);
		cyc(20);
		chk(drv, 1'b1);
		wr(`MC_OVERCURRENT_CONFIG, {13'h0, `MC_OCP_OFF});
		vds <= 6'h01;
		cyc(6);
		chk({ocs, drv}, 2'b01);
		vds <= 6'h00;
	endtask
	// ==================================================
	// main sequence
	initial begin
		cyc(8);
		rst <= 1'b0;
		cyc(1);
		t_startup();
		t_standby(1'b0);
		wr(`MC_PIN_OPTION_CONFIG, 16'h0010);
		spd <= 1'b0;
		t_standby(1'b1);
		wr(`MC_PIN_OPTION_CONFIG, IMG[6]);
		t_redirect();
		t_refuse();
		t_modes();
		t_deadtime();
		t_faults();
		print_verdict();
	end
endmodule // test_motor_ctrl_i2c_config_regs
